// ===== irs_consts.vh
/*
 Constants for the interleaved request scheduler: packet codes, timing
 counts in request cycles, field layout of the sampled request word.
 Assumes inclusion by the design, controller and bench files.
*/
`ifndef IRS_CONSTS_VH
`define IRS_CONSTS_VH
`define IRS_OP_W          2
`define IRS_OP_NOP        2'h0
`define IRS_OP_ACT        2'h1
`define IRS_OP_COL        2'h2
`define IRS_OP_PRE        2'h3
`define IRS_REQ_W         12
`define IRS_OP_HI         11
`define IRS_OP_LO         10
`define IRS_WR_BIT        9
`define IRS_COLUMN_DELAY_FIELD_BIT      8
`define IRS_PDLY_HI       7
`define IRS_PDLY_LO       6
`define IRS_BANK_HI       5
`define IRS_BANK_LO       3
`define IRS_COL_HI        2
`define IRS_COL_LO        0
`define IRS_DATA_W        16
`define IRS_CWD_CYC       4'h3
`define IRS_CAC_CYC       4'h6
`define IRS_CC_CYC        4'h2
`define IRS_PIPE_LEN      16
`define IRS_FIFO_DEPTH    8
`endif

// ===== irs_fifo.v
/*
 Parameterised FIFO with valid/ready on both sides.
 Assumes a single clock and synchronous active-high reset.
*/
`default_nettype none
module irs_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             reset,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;
	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
		if (reset)
		begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // irs_fifo
`default_nettype wire

// ===== irs_sched.v
/*
 Device side of the request path: samples the request pins on rising edges of
 the received request clock, applies delayed column and precharge
 commands, captures write data and returns read data at fixed delays.
 Assumes the controller keeps all spacing constraints it is bound to.
*/
`default_nettype none
`include "irs_consts.vh"
// Operation
// - Column-delay field: apply column one cycle later
// - Precharge delay field postpones the precharge
// - Write data captured write-data-delay after column
// - Read data returned read-data-delay after column
// - Write-read bus gap follows from delays
module irs_sched (
	input  wire                    clk,
	input  wire                    reset,
	input  wire                    req_clk,
	input  wire [`IRS_REQ_W-1:0]   request_pins,
	input  wire [`IRS_DATA_W-1:0]  dq_in,
	output reg  [`IRS_DATA_W-1:0]  dq_out,
	output reg                     dq_oe,
	output reg                     row_activate_cmd,
	output reg                     precharge_cmd,
	output reg                     column_cmd,
	output reg                     column_write,
	output reg  [2:0]              cmd_bank,
	output reg  [2:0]              cmd_column,
	output reg                     wr_data_valid,
	output reg  [`IRS_DATA_W-1:0]  wr_data,
	input  wire                    rd_data_valid,
	output reg                     rd_data_ready,
	input  wire [`IRS_DATA_W-1:0]  rd_data
);
	reg                    ck_s1_q;
	reg                    ck_s2_q;
	reg                    ck_old_q;
	reg [`IRS_REQ_W-1:0]   rq_s1_q;
	reg [`IRS_REQ_W-1:0]   rq_s2_q;
	reg [`IRS_DATA_W-1:0]  dq_s1_q;
	reg [`IRS_DATA_W-1:0]  dq_s2_q;
	reg [`IRS_PIPE_LEN-1:0] colw_q;
	reg [`IRS_PIPE_LEN-1:0] colr_q;
	reg [`IRS_PIPE_LEN-1:0] wdat_q;
	reg [`IRS_PIPE_LEN-1:0] rdat_q;
	reg [2:0]              colb_q [0:1];
	reg [2:0]              colc_q [0:1];
	reg [3:0]              pre_q;
	reg [2:0]              preb_q [0:3];
	reg [`IRS_DATA_W-1:0]  hold_q;
	reg                    fill_q;
	wire                   tick;
	wire [1:0]             op;
	wire                   f_valid;
	wire [`IRS_DATA_W-1:0] f_data;
	wire                   f_in_ready;
	wire                   f_pop;
	integer                i;
	function [`IRS_PIPE_LEN-1:0] tap;
		input [3:0] d;
		begin
			// Bit d-1: the entry falls due d ticks later
			tap = ({{(`IRS_PIPE_LEN-1){1'b0}}, 1'b1} << d) >> 1;
		end
	endfunction
	assign tick = ck_s2_q & ~ck_old_q;
	assign op   = rq_s2_q[`IRS_OP_HI:`IRS_OP_LO];
	// Read data source stalls when the return FIFO is full
	assign f_pop = tick & rdat_q[0];
	irs_fifo #(
		.WIDTH (`IRS_DATA_W),
		.DEPTH (`IRS_FIFO_DEPTH),
		.AW    (3)
	) i_irs_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (rd_data_valid),
		.in_ready  (f_in_ready),
		.in_data   (rd_data),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);
	always @(posedge clk)
	begin
		ck_s1_q <= req_clk;
		ck_s2_q <= ck_s1_q;
		rq_s1_q <= request_pins;
		rq_s2_q <= rq_s1_q;
		dq_s1_q <= dq_in;
		dq_s2_q <= dq_s1_q;
		if (reset)
		begin
			ck_old_q         <= 1'b0;
			colw_q           <= {`IRS_PIPE_LEN{1'b0}};
			colr_q           <= {`IRS_PIPE_LEN{1'b0}};
			wdat_q           <= {`IRS_PIPE_LEN{1'b0}};
			rdat_q           <= {`IRS_PIPE_LEN{1'b0}};
			pre_q            <= 4'h0;
			dq_out           <= {`IRS_DATA_W{1'b0}};
			dq_oe            <= 1'b0;
			row_activate_cmd <= 1'b0;
			precharge_cmd    <= 1'b0;
			column_cmd       <= 1'b0;
			column_write     <= 1'b0;
			cmd_bank         <= 3'h0;
			cmd_column       <= 3'h0;
			wr_data_valid    <= 1'b0;
			wr_data          <= {`IRS_DATA_W{1'b0}};
			rd_data_ready    <= 1'b0;
			hold_q           <= {`IRS_DATA_W{1'b0}};
			fill_q           <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
				preb_q[i] <= 3'h0;
			for (i = 0; i < 2; i = i + 1)
			begin
				colb_q[i] <= 3'h0;
				colc_q[i] <= 3'h0;
			end
		end
		else
		begin
			ck_old_q         <= ck_s2_q;
			rd_data_ready    <= f_in_ready;
			row_activate_cmd <= 1'b0;
			precharge_cmd    <= 1'b0;
			column_cmd       <= 1'b0;
			wr_data_valid    <= 1'b0;
			if (tick)
			begin
				colw_q <= colw_q >> 1;
				colr_q <= colr_q >> 1;
				wdat_q <= wdat_q >> 1;
				rdat_q <= rdat_q >> 1;
				pre_q  <= pre_q >> 1;
				colb_q[0] <= colb_q[1];
				colc_q[0] <= colc_q[1];
				for (i = 0; i < 3; i = i + 1)
					preb_q[i] <= preb_q[i+1];
				if (op == `IRS_OP_ACT)
				begin
					row_activate_cmd <= 1'b1;
					cmd_bank <= rq_s2_q[`IRS_BANK_HI:`IRS_BANK_LO];
				end
				else if (op == `IRS_OP_COL &&
					!rq_s2_q[`IRS_COLUMN_DELAY_FIELD_BIT])
				begin
					column_cmd   <= 1'b1;
					column_write <= rq_s2_q[`IRS_WR_BIT];
					cmd_bank   <= rq_s2_q[`IRS_BANK_HI:`IRS_BANK_LO];
					cmd_column <= rq_s2_q[`IRS_COL_HI:`IRS_COL_LO];
				end
				else if (colw_q[0] | colr_q[0])
				begin
					column_cmd   <= 1'b1;
					column_write <= colw_q[0];
					cmd_bank     <= colb_q[0];
					cmd_column   <= colc_q[0];
				end
				if (op == `IRS_OP_COL && rq_s2_q[`IRS_COLUMN_DELAY_FIELD_BIT])
				begin
					colb_q[0] <= rq_s2_q[`IRS_BANK_HI:`IRS_BANK_LO];
					colc_q[0] <= rq_s2_q[`IRS_COL_HI:`IRS_COL_LO];
					if (rq_s2_q[`IRS_WR_BIT])
						colw_q <= (colw_q >> 1) | tap(4'h1);
					else
						colr_q <= (colr_q >> 1) | tap(4'h1);
				end
				if (op == `IRS_OP_COL)
				begin
					if (rq_s2_q[`IRS_WR_BIT])
						wdat_q <= (wdat_q >> 1) | tap(`IRS_CWD_CYC
							+ {3'h0, rq_s2_q[`IRS_COLUMN_DELAY_FIELD_BIT]});
					else
						rdat_q <= (rdat_q >> 1) | tap(`IRS_CAC_CYC
							+ {3'h0, rq_s2_q[`IRS_COLUMN_DELAY_FIELD_BIT]});
				end
				if (pre_q[0])
				begin
					precharge_cmd <= 1'b1;
					cmd_bank      <= preb_q[0];
				end
				// Zero delay applies at once, else parks d-1 stages out
				if (op == `IRS_OP_PRE &&
					rq_s2_q[`IRS_PDLY_HI:`IRS_PDLY_LO] == 2'h0)
				begin
					precharge_cmd <= 1'b1;
					cmd_bank      <= rq_s2_q[`IRS_BANK_HI:`IRS_BANK_LO];
				end
				else if (op == `IRS_OP_PRE)
				begin
					pre_q <= (pre_q >> 1) | (4'h1 <<
						(rq_s2_q[`IRS_PDLY_HI:`IRS_PDLY_LO] - 2'h1));
					preb_q[rq_s2_q[`IRS_PDLY_HI:`IRS_PDLY_LO] - 2'h1] <=
						rq_s2_q[`IRS_BANK_HI:`IRS_BANK_LO];
				end
				if (wdat_q[0])
				begin
					wr_data_valid <= 1'b1;
					wr_data       <= dq_s2_q;
				end
				// Drive each read packet back-to-back; gap set by delays
				if (rdat_q[0])
				begin
					dq_oe  <= 1'b1;
					dq_out <= f_valid ? f_data : hold_q;
				end
				else
					dq_oe <= 1'b0;
			end
			if (f_valid && !fill_q)
			begin
				hold_q <= f_data;
				fill_q <= 1'b1;
			end
		end
	end
endmodule // irs_sched
`default_nettype wire

// ===== irs_sched_chk_asserts.sv
/* Port checks for irs_sched, bound to every instance.
 Assumes clk and a synchronous active-high reset. */
`default_nettype none
module irs_sched_chk (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        req_clk,
	input wire logic [11:0] request_pins,
	input wire logic [15:0] dq_in,
	input wire logic [15:0] dq_out,
	input wire logic        dq_oe,
	input wire logic        row_activate_cmd,
	input wire logic        precharge_cmd,
	input wire logic        column_cmd,
	input wire logic        column_write,
	input wire logic [2:0]  cmd_bank,
	input wire logic [2:0]  cmd_column,
	input wire logic        wr_data_valid,
	input wire logic [15:0] wr_data,
	input wire logic        rd_data_valid,
	input wire logic        rd_data_ready,
	input wire logic [15:0] rd_data
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (reset);
	a_wr_capture: assert property (
		column_cmd && column_write |-> ##[20:28] wr_data_valid)
		else $error("write data capture late");
	a_rd_return: assert property (
		column_cmd && !column_write |-> ##[44:52] $rose(dq_oe))
		else $error("read data return late");
	a_rd_hold: assert property ($rose(dq_oe) |-> dq_oe[*6])
		else $error("read packet cut short");
	a_col_once: assert property (column_cmd |=> !column_cmd)
		else $error("column applied twice");
	a_pre_once: assert property (precharge_cmd |=> !precharge_cmd)
		else $error("precharge applied twice");
	cover property (column_cmd && column_write);
	cover property (column_cmd && !column_write);
	cover property (precharge_cmd);
endmodule // irs_sched_chk
bind irs_sched irs_sched_chk i_irs_sched_chk (.*);
`default_nettype wire

// ===== irs_ctl.sv
/* Controller model: request clock, request words, write data.
 Assumes the bench calls put or ilv once reset is over. */
`default_nettype none
`include "irs_consts.vh"
module irs_ctl (
	output var logic        req_clk,
	output var logic [11:0] request_pins,
	output var logic [15:0] dq_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] qa[$], qc[$], qp[$];
	logic [15:0] qw[$], wd[16];
	logic        wv[16] = '{default: 0};
	int          cyc = 0;
	initial
	begin
		req_clk = 0;
		request_pins = 0;
		dq_in = 16'hA5A5;
		forever #100 req_clk = ~req_clk;
	end
	// One request cycle: word on pins, due write data on the bus
	task automatic put(input logic [11:0] w);
		logic [63:0] e;
		int          dl;
		@(negedge req_clk);
		request_pins <= w;
		dq_in <= wv[cyc%16] ? wd[cyc%16] : ~dq_in;
		wv[cyc%16] = 0;
		dl = w[11:10] == `IRS_OP_COL ? w[8] : 0;
		dl = w[11:10] == `IRS_OP_PRE ? w[7:6] : dl;
		e = {57'($time + 100 + 200 * dl), w[9], w[5:0]};
		case (w[11:10])
			`IRS_OP_ACT: qa.push_back(e);
			`IRS_OP_COL: qc.push_back(e);
			`IRS_OP_PRE: qp.push_back(e);
			default: ;
		endcase
		if (w[11:10] == `IRS_OP_COL && w[9])
		begin
			qw.push_back(16'($urandom));
			wd[(cyc+3+dl)%16] = qw[$];
			wv[(cyc+3+dl)%16] = 1;
		end
		cyc++;
	endtask
	// Page-empty interleave: act each 4th slot, two columns, precharge
	task automatic ilv(input logic wr, input int n, input logic [2:0] b0);
		int         cd, pd, nb, m, s;
		logic [1:0] op[4];
		cd = wr ? 1 : 5;
		pd = wr ? 14 : 10;
		nb = wr ? 5 : 4;
		op = '{`IRS_OP_ACT, `IRS_OP_COL, `IRS_OP_PRE, `IRS_OP_COL};
		for (int t = 0; t < 4 * n + pd; t++)
		begin
			m = t % 4;
			s = m == 0 ? t : m == 2 ? t - pd : t - cd - (m == 3 ? 2 : 0);
			if (s >= 0 && s % 4 == 0 && s / 4 < n)
				put({op[m], wr, 3'h0, 3'(b0 + s / 4 % nb), 3'(s / 2 + m / 3)});
			else
				put(0);
		end
		repeat (8) put(0);
	endtask
endmodule // irs_ctl
`default_nettype wire

// ===== irs_sched_test.sv
/* Self-checking bench for irs_sched with the controller model.
 Assumes irs_sched_chk is bound to the design. */
`default_nettype none
`include "irs_consts.vh"
module irs_sched_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, reset, req_clk, dq_oe, row_activate_cmd, oe_q;
	logic        precharge_cmd, column_cmd, column_write, wr_data_valid;
	logic        rd_data_valid, rd_data_ready;
	logic [11:0] request_pins;
	logic [15:0] dq_in, dq_out, wr_data, rd_data, rq[$];
	logic [2:0]  cmd_bank, cmd_column;
	int          n_fail = 0, check_count = 0, cyc_n = 0, nacc = 0;
	irs_sched i_irs_sched (.*);
	irs_ctl i_irs_ctl (.*);
	task automatic cmp(string s, logic [63:0] x, logic [63:0] g);
		check_count++;
		if (g !== x)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic chk_ev(string s, ref logic [63:0] q[$],
		input logic [6:0] v, m);
		logic [63:0] e;
		e = q.size() ? q.pop_front() : '1;
		cmp(s, e[6:0] & m, v & m);
		cmp(s, 1, $time > e[63:7] + 25 && $time < e[63:7] + 175);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		oe_q <= dq_oe;
		if (!reset && row_activate_cmd)
			chk_ev("act", i_irs_ctl.qa, {1'h0, cmd_bank, 3'h0}, 7'h38);
		if (!reset && column_cmd)
			chk_ev("col", i_irs_ctl.qc, {column_write, cmd_bank, cmd_column}, 7'h7F);
		if (!reset && precharge_cmd)
			chk_ev("pre", i_irs_ctl.qp, {1'h0, cmd_bank, 3'h0}, 7'h38);
		if (!reset && wr_data_valid)
			cmp("wr_data", i_irs_ctl.qw.pop_front(), wr_data);
		if (!reset && dq_oe && !oe_q)
			cmp("dq_out", rq.pop_front(), dq_out);
		if (++cyc_n > 4000)
		begin
			n_fail++;
			conclude;
		end
	end
	initial
	begin
		reset = 1;
		rd_data_valid = 0;
		rd_data = 0;
		void'($urandom(32'h1373));
		repeat (5) @(posedge clk);
		reset <= 0;
		repeat (3) @(posedge clk);
		i_irs_ctl.ilv(1, 5, 3'($urandom));
		$display("write interleave done");
		for (int i = 0; i < 6; i++)
		begin
			i_irs_ctl.put({`IRS_OP_COL, 2'h3, 2'h0, 3'($urandom),
				3'(i)});
			i_irs_ctl.put(0);
		end
		repeat (4) i_irs_ctl.put(0);
		$display("column delay done");
		for (int p = 0; p < 4; p++)
		begin
			i_irs_ctl.put({`IRS_OP_PRE, 2'h0, 2'(p), 3'(p), 3'h0});
			repeat (3) i_irs_ctl.put(0);
		end
		$display("precharge delay done");
		repeat (10)
		begin
			@(posedge clk);
			if (rd_data_ready)
			begin
				rq.push_back(16'($urandom));
				rd_data <= rq[$];
				rd_data_valid <= 1;
				nacc++;
				@(posedge clk);
				rd_data_valid <= 0;
			end
			repeat (2) @(posedge clk);
		end
		cmp("fifo fill", `IRS_FIFO_DEPTH, nacc);
		$display("fifo fill done");
		i_irs_ctl.ilv(0, 4, 3'($urandom));
		cmp("fifo drained", 0, rq.size());
		$display("read interleave done");
		conclude;
	end
endmodule // irs_sched_test
`default_nettype wire
